// File: pin_mux_defs.vh
// constants for the dual subsystem pin multiplexer
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH
`define NPINS            66
`define NBANKS           9
`define NTRIP            12
`define NWAKE            64
`define MPRI             11
`define MALT             4
`define CSEL             4
// register indices (byte address = index * 4)
`define REG_PCTL_BASE    8'h00
`define REG_APSEL_LO     8'h50
`define REG_APSEL_HI     8'h51
`define REG_APSEL_X      8'h52
`define REG_OWNER_LO     8'h53
`define REG_OWNER_HI     8'h54
`define REG_OWNER_X      8'h55
`define REG_CMUX_BASE    8'h56
`define REG_OE_LO        8'h5c
`define REG_OE_HI        8'h5d
`define REG_OE_X         8'h5e
`define REG_PU_LO        8'h5f
`define REG_PU_HI        8'h60
`define REG_PU_X         8'h61
`define REG_AMSEL        8'h62
`define REG_TRIPSEL_BASE 8'h63
`define REG_IRQ_STAT     8'h66
`define REG_IRQ_MASK     8'h67
`define REG_PIN_LO       8'h68
`define REG_PIN_HI       8'h69
`define REG_PIN_X        8'h6a
`define REG_GPO_LO       8'h6b
`define REG_GPO_HI       8'h6c
`define REG_GPO_X        8'h6d
`define PIN_F6           38
`define PIN_G2           42
`define PIN_G5           45
`define PIN_G6           46
`define PIN_J7           63
`define SILICON_REV0     1'b0
`endif

// File: pin_mux.v
// dual subsystem pin multiplexer for the 66-pin bank
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "pin_mux_defs.vh"
module pin_mux #(
   parameter REV0 = `SILICON_REV0
) (
   input  wire           clk,
   input  wire           resetn,
   input  wire [7:0]     addr,
   input  wire [31:0]    wdata,
   input  wire           wr,
   input  wire           rd,
   output reg  [31:0]    rdata,
   input  wire [65:0]    pin_in,
   output wire [65:0]    pin_out,
   output wire [65:0]    pin_oe,
   output wire [65:0]    pin_pullup,
   output wire [3:0]     usb_analog_en,
   input  wire [1055:0]  m_periph_out,
   input  wire [1055:0]  m_periph_oe,
   output wire [1055:0]  m_periph_in,
   input  wire [263:0]   c_periph_out,
   input  wire [263:0]   c_periph_oe,
   output wire [263:0]   c_periph_in,
   output wire [65:0]    control_input_lines,
   output wire [63:0]    standby_wakeup_cand,
   output wire [11:0]    trip_event_lines,
   output wire [8:0]     bank_irq,
   output wire           irq,
   output wire           external_oscillator_input
);
   // per pin: 4-bit function code (0 gpio, 1..11 primary, 12..15 alt)
   reg  [263:0] pctl_r;
   reg  [65:0]  apsel_r;
   reg  [65:0]  owner_r;
   reg  [131:0] cmux_r;
   reg  [65:0]  gpo_oe_r;
   reg  [65:0]  pu_r;
   reg  [65:0]  gpo_r;
   reg  [3:0]   amsel_r;
   reg  [95:0]  tripsel_r;
   reg  [8:0]   irq_stat_r;
   reg  [8:0]   irq_mask_r;
   reg  [65:0]  pin_d_r;
   reg  [31:0]  rdata_nxt;
   wire [65:0]  m_out;
   wire [65:0]  m_oe;
   wire [65:0]  c_out;
   wire [65:0]  c_oe;
   wire [65:0]  dig_ok;
   wire [65:0]  rise;
   wire [8:0]   bank_ev;

   genvar g;
   generate
      for (g = 0; g < 66; g = g + 1) begin : pin_g
         wire [3:0] f   = pctl_r[g*4 +: 4];
         wire [1:0] cs  = cmux_r[g*2 +: 2];
         wire       alt = f >= 4'hc;
         // alternate code only reaches pin when alternate source chosen
         wire       msel = (f != 4'h0) && (alt == apsel_r[g]);
         wire       csel = (cs != 2'b00);
         wire       an = (g == `PIN_F6) ? amsel_r[0] :
                         (g == `PIN_G2) ? amsel_r[1] :
                         (g == `PIN_G5) ? amsel_r[2] :
                         (g == `PIN_G6) ? amsel_r[3] : 1'b0;
         wire       r0 = REV0 && (g == `PIN_F6 || g == `PIN_G6);
         assign dig_ok[g] = !an && !r0;
         assign m_out[g] = msel ? m_periph_out[g*16 + f] : gpo_r[g];
         assign m_oe[g]  = msel ? m_periph_oe[g*16 + f] : gpo_oe_r[g];
         assign c_out[g] = csel ? c_periph_out[g*4 + cs] : gpo_r[g];
         assign c_oe[g]  = csel ? c_periph_oe[g*4 + cs] : gpo_oe_r[g];
         // owner bit picks subsystem; gpio falls back to gpo registers
         assign pin_out[g] = owner_r[g] ? c_out[g] : m_out[g];
         assign pin_oe[g]  = dig_ok[g] &
                             (owner_r[g] ? c_oe[g] : m_oe[g]);
         assign pin_pullup[g] = pu_r[g] & dig_ok[g];
         genvar k;
         for (k = 0; k < 16; k = k + 1) begin : mi_g
            assign m_periph_in[g*16 + k] = dig_ok[g] & !owner_r[g] &
               msel & (f == k) & pin_in[g];
         end
         for (k = 0; k < 4; k = k + 1) begin : ci_g
            assign c_periph_in[g*4 + k] = dig_ok[g] & owner_r[g] &
               csel & (cs == k) & pin_in[g];
         end
         assign control_input_lines[g] = dig_ok[g] & pin_in[g];
         assign rise[g] = pin_in[g] & !pin_d_r[g];
      end
      for (g = 0; g < 12; g = g + 1) begin : trip_g
         wire [5:0] s = tripsel_r[g*8 +: 6];
         // pins 39 and 44 cannot feed trips
         assign trip_event_lines[g] = (s != 6'd39) && (s != 6'd44) &&
                                      control_input_lines[s];
      end
      for (g = 0; g < 64; g = g + 1) begin : wake_g
         if (g == 39 || g == 44) begin : nw
            assign standby_wakeup_cand[g] = 1'b0;
         end else begin : w
            assign standby_wakeup_cand[g] = control_input_lines[g];
         end
      end
      for (g = 0; g < 9; g = g + 1) begin : bank_g
         // banks of eight; last bank holds only pins 64, 65
         if (g < 8) begin : full
            wire [7:0] sel = ~owner_r[g*8 +: 8] & dig_ok[g*8 +: 8];
            assign bank_ev[g] = |(rise[g*8 +: 8] & sel);
         end else begin : part
            assign bank_ev[g] =
               |(rise[65:64] & ~owner_r[65:64] & dig_ok[65:64]);
         end
         assign bank_irq[g] = irq_stat_r[g] & irq_mask_r[g];
      end
   endgenerate

   assign usb_analog_en = amsel_r | (REV0 ? 4'h9 : 4'h0);
   assign external_oscillator_input = pin_in[`PIN_J7];
   assign irq = |(irq_stat_r & irq_mask_r);

   always @* begin
      rdata_nxt = 32'h00000000;
      if (addr < 8'h42) begin
         if (addr[0])
            rdata_nxt = {28'h0000000, pctl_r[addr*4 +: 4]};
         else
            rdata_nxt = {28'h0000000, pctl_r[addr*4 +: 4]};
      end
      case (addr)
         `REG_APSEL_LO: rdata_nxt = apsel_r[31:0];
         `REG_APSEL_HI: rdata_nxt = apsel_r[63:32];
         `REG_APSEL_X:  rdata_nxt = {30'h0, apsel_r[65:64]};
         `REG_OWNER_LO: rdata_nxt = owner_r[31:0];
         `REG_OWNER_HI: rdata_nxt = owner_r[63:32];
         `REG_OWNER_X:  rdata_nxt = {30'h0, owner_r[65:64]};
         8'h56:         rdata_nxt = {16'h0, cmux_r[15:0]};
         8'h57:         rdata_nxt = {16'h0, cmux_r[31:16]};
         8'h58:         rdata_nxt = {16'h0, cmux_r[47:32]};
         8'h59:         rdata_nxt = {16'h0, cmux_r[63:48]};
         8'h5a:         rdata_nxt = cmux_r[95:64];
         8'h5b:         rdata_nxt = {28'h0, cmux_r[131:128]} |
                                    {cmux_r[127:96] & 32'h00000000};
         `REG_OE_LO:    rdata_nxt = gpo_oe_r[31:0];
         `REG_OE_HI:    rdata_nxt = gpo_oe_r[63:32];
         `REG_OE_X:     rdata_nxt = {30'h0, gpo_oe_r[65:64]};
         `REG_PU_LO:    rdata_nxt = pu_r[31:0];
         `REG_PU_HI:    rdata_nxt = pu_r[63:32];
         `REG_PU_X:     rdata_nxt = {30'h0, pu_r[65:64]};
         `REG_AMSEL:    rdata_nxt = {28'h0, amsel_r};
         8'h63:         rdata_nxt = tripsel_r[31:0];
         8'h64:         rdata_nxt = tripsel_r[63:32];
         8'h65:         rdata_nxt = tripsel_r[95:64];
         `REG_IRQ_STAT: rdata_nxt = {23'h0, irq_stat_r};
         `REG_IRQ_MASK: rdata_nxt = {23'h0, irq_mask_r};
         `REG_PIN_LO:   rdata_nxt = pin_in[31:0];
         `REG_PIN_HI:   rdata_nxt = pin_in[63:32];
         `REG_PIN_X:    rdata_nxt = {30'h0, pin_in[65:64]};
         `REG_GPO_LO:   rdata_nxt = gpo_r[31:0];
         `REG_GPO_HI:   rdata_nxt = gpo_r[63:32];
         `REG_GPO_X:    rdata_nxt = {30'h0, gpo_r[65:64]};
         default:       rdata_nxt = rdata_nxt;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pctl_r     <= 264'h0;
         apsel_r    <= 66'h0;
         owner_r    <= 66'h0;
         cmux_r     <= 132'h0;
         gpo_oe_r   <= 66'h0;
         pu_r       <= 66'h0;
         gpo_r      <= 66'h0;
         amsel_r    <= 4'h0;
         tripsel_r  <= 96'h0;
         irq_stat_r <= 9'h0;
         irq_mask_r <= 9'h0;
         pin_d_r    <= 66'h0;
         rdata      <= 32'h0;
      end else begin
         pin_d_r <= pin_in;
         rdata   <= rd ? rdata_nxt : 32'h0;
         // read clears status; new events win over the clear
         if (rd && addr == `REG_IRQ_STAT)
            irq_stat_r <= bank_ev;
         else
            irq_stat_r <= irq_stat_r | bank_ev;
         if (wr) begin
            if (addr < 8'h42)
               pctl_r[addr*4 +: 4] <= wdata[3:0];
            case (addr)
               `REG_APSEL_LO: apsel_r[31:0]   <= wdata;
               `REG_APSEL_HI: apsel_r[63:32]  <= wdata;
               `REG_APSEL_X:  apsel_r[65:64]  <= wdata[1:0];
               `REG_OWNER_LO: owner_r[31:0]   <= wdata;
               `REG_OWNER_HI: owner_r[63:32]  <= wdata;
               `REG_OWNER_X:  owner_r[65:64]  <= wdata[1:0];
               8'h56:         cmux_r[15:0]    <= wdata[15:0];
               8'h57:         cmux_r[31:16]   <= wdata[15:0];
               8'h58:         cmux_r[47:32]   <= wdata[15:0];
               8'h59:         cmux_r[63:48]   <= wdata[15:0];
               8'h5a:         cmux_r[95:64]   <= wdata;
               8'h5b:         cmux_r[131:96]  <= {wdata[3:0], wdata};
               `REG_OE_LO:    gpo_oe_r[31:0]  <= wdata;
               `REG_OE_HI:    gpo_oe_r[63:32] <= wdata;
               `REG_OE_X:     gpo_oe_r[65:64] <= wdata[1:0];
               `REG_PU_LO:    pu_r[31:0]      <= wdata;
               `REG_PU_HI:    pu_r[63:32]     <= wdata;
               `REG_PU_X:     pu_r[65:64]     <= wdata[1:0];
               `REG_AMSEL:    amsel_r         <= wdata[3:0];
               8'h63:         tripsel_r[31:0] <= wdata;
               8'h64:         tripsel_r[63:32] <= wdata;
               8'h65:         tripsel_r[95:64] <= wdata;
               `REG_IRQ_MASK: irq_mask_r      <= wdata[8:0];
               `REG_GPO_LO:   gpo_r[31:0]     <= wdata;
               `REG_GPO_HI:   gpo_r[63:32]    <= wdata;
               `REG_GPO_X:    gpo_r[65:64]    <= wdata[1:0];
               default:       ;
            endcase
         end
      end
   end
endmodule // pin_mux

// File: pin_mux_monitor.sv
// port assertions for the pin multiplexer
`timescale 1ns/100ps
module pin_mux_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic [65:0] pin_in,
   input wire logic [65:0] pin_oe,
   input wire logic [65:0] pin_pullup,
   input wire logic [3:0]  usb_analog_en,
   input wire logic [65:0] control_input_lines,
   input wire logic [63:0] standby_wakeup_cand,
   input wire logic [8:0]  bank_irq,
   input wire logic        irq,
   input wire logic        external_oscillator_input
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_osc_direct: assert property (
      external_oscillator_input == pin_in[63]) else $error("osc lost");
   a_reset_quiet: assert property (
      $rose(resetn) |-> pin_oe == 66'h0 && pin_pullup == 66'h0)
      else $error("pins active after reset");
   a_read_idle: assert property (
      !$past(rd) |-> rdata == 32'h0) else $error("rdata without read");
   a_analog_drive: assert property (
      usb_analog_en[0] |-> !pin_oe[38]) else $error("analog pin driven");
   a_analog_input: assert property (
      usb_analog_en[0] |-> !control_input_lines[38])
      else $error("analog pin seen");
   a_wake_gap: assert property (
      !standby_wakeup_cand[39] && !standby_wakeup_cand[44])
      else $error("wake gap pin set");
   a_wake_pass: assert property (
      standby_wakeup_cand[0] == pin_in[0]) else $error("wake line wrong");
   a_input_qualifier_pass: assert property (
      control_input_lines[65] == pin_in[65]) else $error("input_qualifier line wrong");
   a_irq_any: assert property (
      irq == |bank_irq) else $error("irq not or of banks");
endmodule // pin_mux_monitor
bind pin_mux pin_mux_monitor i_mon (.clk, .resetn, .rd, .rdata, .pin_in,
   .pin_oe, .pin_pullup, .usb_analog_en, .control_input_lines,
   .standby_wakeup_cand, .bank_irq, .irq, .external_oscillator_input);

// File: board_model.sv
// board levels and peripheral signals around the pin multiplexer
`timescale 1ns/100ps
module board_model (
   input  wire logic [65:0] ext_lvl,
   input  wire logic [65:0] pin_out,
   input  wire logic [65:0] pin_oe,
   output logic [65:0]      pin_in,
   output logic [1055:0]    m_out,
   output logic [1055:0]    m_oe,
   output logic [263:0]     c_out,
   output logic [263:0]     c_oe
);
   // board drives every pad the mux leaves undriven
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
   assign m_out = {66{16'h5a3c}};
   assign m_oe = {66{16'hfff0}};
   assign c_out = {66{4'ha}};
   assign c_oe = {66{4'he}};
endmodule // board_model

// File: testbench.sv
// self-checking testbench for the pin multiplexer
`timescale 1ns/100ps
module testbench;
   logic          clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]    addr = 8'h00;
   logic [31:0]   wdata = 32'h0, rdata, d;
   logic [65:0]   ext_lvl = 66'h80_0000_0004, pin_in, pin_out, pin_oe;
   logic [65:0]   pin_pullup, cil;
   logic [1055:0] mo, moe, mi;
   logic [263:0]  co, coe, ci;
   logic [63:0]   wake;
   logic [11:0]   trip;
   logic [8:0]    birq;
   logic [3:0]    usb;
   logic          irq, osc;
   int            err_count = 0, tests_run = 0;
   pin_mux #(.REV0(1'b0)) i_pin_mux (.clk, .resetn, .addr, .wdata, .wr,
      .rd, .rdata, .pin_in, .pin_out, .pin_oe, .pin_pullup,
      .usb_analog_en(usb), .m_periph_out(mo), .m_periph_oe(moe),
      .m_periph_in(mi), .c_periph_out(co), .c_periph_oe(coe),
      .c_periph_in(ci), .control_input_lines(cil),
      .standby_wakeup_cand(wake), .trip_event_lines(trip),
      .bank_irq(birq), .irq, .external_oscillator_input(osc));
   board_model i_board_model (.ext_lvl, .pin_out, .pin_oe, .pin_in,
      .m_out(mo), .m_oe(moe), .c_out(co), .c_oe(coe));
   initial forever #5 clk = ~clk;
   task automatic chk(string n, logic [65:0] e, logic [65:0] g);
      tests_run++;
      if (e !== g) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic t_reset_gpio;
      rreg(8'h53);
      chk("owner", 0, d);
      chk("oe", 0, pin_oe | pin_pullup);
      wreg(8'h5c, 32'h20);
      wreg(8'h6b, 32'h20);
      wreg(8'h5f, 32'h1);
      chk("gpo", 3'h7, {pin_oe[5], pin_out[5], pin_pullup[0]});
      rreg(8'h68);
      chk("pins", 32'h24, d);
      wreg(8'h7f, 32'hffffffff);
      rreg(8'h7f);
      chk("unmapped", 0, d);
   endtask
   task automatic t_master;
      for (int c = 1; c < 16; c++) begin
         wreg(8'h02, c);
         wreg(8'h50, c > 11 ? 32'h4 : 32'h0);
         chk("m_oe", moe[32+c], pin_oe[2]);
         chk("m_io", {mo[32+c] & moe[32+c], pin_in[2]},
            {pin_out[2] & pin_oe[2], mi[32+c]});
      end
      wreg(8'h50, 32'h0);
      chk("alt_off", 2'h0, {pin_oe[2], mi[47]});
      wreg(8'h02, 32'h0);
   endtask
   task automatic t_control;
      wreg(8'h53, 32'h4);
      for (int s = 1; s < 4; s++) begin
         wreg(8'h56, s << 4);
         chk("c_oe", coe[8+s], pin_oe[2]);
         chk("c_io", {co[8+s] & coe[8+s], pin_in[2], 1'b0},
            {pin_out[2] & pin_oe[2], ci[8+s], mi[32]});
      end
      wreg(8'h56, 32'h0);
      chk("c_gpio", 0, pin_oe[2]);
      wreg(8'h53, 32'h0);
   endtask
   task automatic t_analog;
      wreg(8'h5d, 32'h40);
      wreg(8'h62, 32'h1);
      chk("usb", 3'h4, {usb, pin_oe[38], cil[38]});
      wreg(8'h62, 32'h0);
      chk("usb_off", 1, pin_oe[38]);
      wreg(8'h5d, 32'h0);
   endtask
   task automatic t_irq;
      rreg(8'h66);
      wreg(8'h67, 32'h1);
      ext_lvl[0] <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("irq", 10'h201, {irq, birq});
      rreg(8'h66);
      chk("status", 32'h1, d);
      chk("cleared", 0, irq);
      wreg(8'h67, 32'h0);
      ext_lvl[0] <= 1'b0;
      @(posedge clk);
      ext_lvl[0] <= 1'b1;
      rreg(8'h66);
      chk("masked", 33'h1, {irq, d});
   endtask
   task automatic t_fanout;
      wreg(8'h63, 32'h2);
      chk("trip", 1, trip[0]);
      wreg(8'h63, 32'h27);
      chk("trip_gap", 0, trip[0]);
      chk("wake", pin_in[63:0] & ~64'h1080_0000_0000, wake);
      chk("input_qualifier", {pin_in, pin_in[63]}, {cil, osc});
   endtask
   task automatic complete_run;
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000 err_count++;
      complete_run;
   end
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_reset_gpio;
      t_master;
      t_control;
      t_analog;
      t_irq;
      t_fanout;
      complete_run;
   end
endmodule // testbench
